// *** servo_and_signal_pulse_unit.sv ***
// servo pulse, servo measure and square wave unit on general pins
`timescale 1ns/1ns
`default_nettype none

module servo_and_signal_pulse_unit
   import pulse_unit_pkg::*;
#(
   parameter int FRAME_US = SERVO_FRAME_US, // servo frame length in us
   parameter int SW = DATA_W                // signal counter width
) (
   input wire logic ref_clk,                      // 20 MHz clock
   input wire logic sys_rst,                      // async reset, high
   input wire logic [ADDR_W-1:0] reg_addr,        // register address
   input wire logic [DATA_W-1:0] reg_wdata,       // write data
   input wire logic reg_wr,                       // write strobe
   input wire logic reg_rd,                       // read strobe
   output logic [DATA_W-1:0] reg_rdata,           // read data, next cycle
   input wire logic [NUM_PINS-1:0] general_io_pin_in,   // pin levels
   output logic [NUM_PINS-1:0] general_io_pin_out,      // pin drive
   output logic [NUM_PINS-1:0] general_io_pin_oe_n      // low drives
);

   // ----------------------------------------------------------------
   // decode and storage
   // ----------------------------------------------------------------
   logic [4:0] grp;                             // address group
   logic [2:0] ch;                              // channel in group
   pin_mode_t mode_reg [NUM_PINS];              // pin function
   logic [NUM_SERVO-1:0] servo_en_reg;          // servo enables
   logic [POS_W-1:0] pos_reg [NUM_SERVO];       // positions
   logic [MEAS_W-1:0] meas_reg [NUM_SERVO];     // high time in us
   logic [NUM_SIG-1:0] sig_en_reg;              // signal enables
   logic [SW-1:0] period_reg [NUM_SIG];         // signal period
   logic [SW-1:0] high_reg [NUM_SIG];           // signal high time
   logic [SW-1:0] phase_reg [NUM_SIG];          // output phase counter
   logic [SW-1:0] count_reg [NUM_SIG];          // input event counter
   logic [NUM_PINS-1:0] level_reg;              // plain output levels
   logic [NUM_PINS-1:0] prev_reg;               // pin levels last cycle
   logic [PRE_W-1:0] pre_reg;                   // us prescaler
   logic [FRAME_W-1:0] frame_reg;               // servo frame in us
   logic us_tick;                               // one per microsecond
   logic [NUM_SERVO-1:0] servo_act;             // servo channel live
   logic [NUM_SIG-1:0] sig_in_act;              // counter live
   logic [NUM_SIG-1:0] sig_out_act;             // wave output live
   logic [NUM_PINS-1:0] pin_out_next;           // next pin level
   logic [NUM_PINS-1:0] pin_oe_n_next;          // next pin enable
   logic [DATA_W-1:0] rdata_next;               // read mux result

   assign grp = reg_addr[7:3];
   assign ch = reg_addr[2:0];
   assign us_tick = (pre_reg == PRE_W'(CYC_PER_US - 1));

   // converts a measured high time in us to a position
   function automatic logic [POS_W-1:0] us_to_pos(
      input logic [MEAS_W-1:0] us);
      if (us <= MEAS_W'(SERVO_MIN_US)) begin
         return '0;
      end else if (us >= MEAS_W'(SERVO_MAX_US)) begin
         return POS_W'(POS_SPAN);
      end else begin
         return POS_W'(us - MEAS_W'(SERVO_MIN_US));
      end
   endfunction : us_to_pos

   // limits a written position to the 1-2 ms span
   function automatic logic [POS_W-1:0] clamp_pos(
      input logic [DATA_W-1:0] v);
      if (v > DATA_W'(POS_SPAN)) begin
         return POS_W'(POS_SPAN);
      end else begin
         return POS_W'(v);
      end
   endfunction : clamp_pos

   // ----------------------------------------------------------------
   // channel activation
   // ----------------------------------------------------------------
   // an enable only counts while the pin holds the matching function
   always_comb begin
      for (int i = 0; i < NUM_SERVO; i++) begin
         if (i <= SERVO_IN_LAST) begin
            servo_act[i] = servo_en_reg[i] &
               (mode_reg[i] == MODE_SERVO_IN);
         end else begin
            servo_act[i] = servo_en_reg[i] &
               (mode_reg[i] == MODE_SERVO_OUT);
         end
      end
      for (int j = 0; j < NUM_SIG; j++) begin
         // signal channel j sits on pin j
         sig_in_act[j] = sig_en_reg[j] &
            (mode_reg[j] == MODE_SIG_IN);
         sig_out_act[j] = sig_en_reg[j] & (j >= SIG_OUT_FIRST) &
            (mode_reg[j] == MODE_SIG_OUT);
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // pin function selectors; unknown codes fall back to input
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            mode_reg[i] <= MODE_RST;
         end
      end else if (reg_wr && grp == GRP_MODE) begin
         unique case (reg_wdata[2:0])
            MODE_INPUT, MODE_OUTPUT, MODE_SERVO_IN, MODE_SERVO_OUT,
            MODE_SIG_OUT, MODE_SIG_IN: begin
               mode_reg[ch] <= pin_mode_t'(reg_wdata[2:0]);
            end
            default: begin
               mode_reg[ch] <= MODE_INPUT;
            end
         endcase
      end
   end

   // enables and plain output levels
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         servo_en_reg <= '0;
         sig_en_reg <= '0;
         level_reg <= '0;
      end else if (reg_wr) begin
         if (grp == GRP_SERVO_EN) begin
            servo_en_reg[ch] <= reg_wdata[0];
         end
         if (grp == GRP_SIG_EN && ch < 3'(NUM_SIG)) begin
            sig_en_reg[ch] <= reg_wdata[0];
         end
         if (grp == GRP_PIN && ch == PIN_CH_LEVEL) begin
            level_reg <= reg_wdata[NUM_PINS-1:0];
         end
      end
   end

   // signal period and high time
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int j = 0; j < NUM_SIG; j++) begin
            period_reg[j] <= SW'(SIG_PERIOD_RST);
            high_reg[j] <= SW'(SIG_HIGH_RST);
         end
      end else if (reg_wr && ch < 3'(NUM_SIG)) begin
         if (grp == GRP_SIG_PERIOD) begin
            period_reg[ch] <= SW'(reg_wdata);
         end
         if (grp == GRP_SIG_HIGH) begin
            high_reg[ch] <= SW'(reg_wdata);
         end
      end
   end

   // ----------------------------------------------------------------
   // servo timebase
   // ----------------------------------------------------------------
   // microsecond prescaler and shared 20 ms frame counter
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_reg <= '0;
         frame_reg <= '0;
      end else begin
         pre_reg <= us_tick ? '0 : pre_reg + 1'b1;
         if (us_tick) begin
            if (frame_reg == FRAME_W'(FRAME_US - 1)) begin
               frame_reg <= '0;
            end else begin
               frame_reg <= frame_reg + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // servo positions and measurement
   // ----------------------------------------------------------------
   // inputs own their position; software writes only the outputs
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_SERVO; i++) begin
            pos_reg[i] <= POS_RST;
            meas_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_SERVO; i++) begin
            if (i <= SERVO_IN_LAST) begin
               if (!servo_act[i]) begin
                  meas_reg[i] <= '0;
               end else if (prev_reg[i] && !general_io_pin_in[i]) begin
                  // falling edge closes the pulse
                  pos_reg[i] <= us_to_pos(meas_reg[i]);
                  meas_reg[i] <= '0;
               end else if (general_io_pin_in[i] && us_tick &&
                            meas_reg[i] != '1) begin
                  meas_reg[i] <= meas_reg[i] + 1'b1;
               end
            end else if (reg_wr && grp == GRP_SERVO_POS &&
                         ch == 3'(i)) begin
               pos_reg[i] <= clamp_pos(reg_wdata);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // signal channels
   // ----------------------------------------------------------------
   // output phase counter wraps at the programmed period
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int j = 0; j < NUM_SIG; j++) begin
            phase_reg[j] <= '0;
         end
      end else begin
         for (int j = 0; j < NUM_SIG; j++) begin
            if (!sig_out_act[j] ||
                phase_reg[j] + 1'b1 >= period_reg[j]) begin
               phase_reg[j] <= '0;
            end else begin
               phase_reg[j] <= phase_reg[j] + 1'b1;
            end
         end
      end
   end

   // event counter; a pulse in the clearing cycle is still counted
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int j = 0; j < NUM_SIG; j++) begin
            count_reg[j] <= '0;
         end
      end else begin
         for (int j = 0; j < NUM_SIG; j++) begin
            if (sig_in_act[j] && general_io_pin_in[j] && !prev_reg[j]) begin
               if (reg_wr && grp == GRP_SIG_COUNT && ch == 3'(j)) begin
                  count_reg[j] <= SW'(1);
               end else begin
                  count_reg[j] <= count_reg[j] + 1'b1;
               end
            end else if (reg_wr && grp == GRP_SIG_COUNT && ch == 3'(j)) begin
               count_reg[j] <= '0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   // choose each pin's level from its function
   always_comb begin
      for (int p = 0; p < NUM_PINS; p++) begin
         pin_out_next[p] = 1'b0;
         pin_oe_n_next[p] = 1'b1;
         unique case (mode_reg[p])
            MODE_OUTPUT: begin
               pin_out_next[p] = level_reg[p];
               pin_oe_n_next[p] = 1'b0;
            end
            MODE_SERVO_OUT: begin
               pin_oe_n_next[p] = 1'b0;
               // servo outputs exist only on pins 4-7
               pin_out_next[p] = servo_act[p] && (frame_reg <
                  FRAME_W'(SERVO_MIN_US) + FRAME_W'(pos_reg[p]));
            end
            MODE_SIG_OUT: begin
               pin_oe_n_next[p] = 1'b0;
               // high at or above a nonzero period keeps phase below it: steady high
               if (p < NUM_SIG) begin
                  pin_out_next[p] = sig_out_act[p] &&
                     (phase_reg[p] < high_reg[p]);
               end
            end
            MODE_INPUT, MODE_SERVO_IN, MODE_SIG_IN: begin
               pin_oe_n_next[p] = 1'b1;
            end
         endcase
      end
   end

   // pin output flops and input history
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         general_io_pin_out <= '0;
         general_io_pin_oe_n <= '1;
         prev_reg <= '0;
      end else begin
         general_io_pin_out <= pin_out_next;
         general_io_pin_oe_n <= pin_oe_n_next;
         prev_reg <= general_io_pin_in;
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = '0;
      unique case (grp)
         GRP_MODE: rdata_next = DATA_W'(mode_reg[ch]);
         GRP_SERVO_EN: rdata_next = DATA_W'(servo_en_reg[ch]);
         GRP_SERVO_POS: rdata_next = DATA_W'(pos_reg[ch]);
         GRP_SIG_EN, GRP_SIG_PERIOD, GRP_SIG_HIGH, GRP_SIG_COUNT: begin
            if (ch < 3'(NUM_SIG)) begin
               if (grp == GRP_SIG_EN) begin
                  rdata_next = DATA_W'(sig_en_reg[ch]);
               end else if (grp == GRP_SIG_PERIOD) begin
                  rdata_next = DATA_W'(period_reg[ch]);
               end else if (grp == GRP_SIG_HIGH) begin
                  rdata_next = DATA_W'(high_reg[ch]);
               end else begin
                  rdata_next = DATA_W'(count_reg[ch]);
               end
            end
         end
         GRP_PIN: begin
            if (ch == PIN_CH_LEVEL) begin
               rdata_next = DATA_W'(level_reg);
            end else if (ch == PIN_CH_INPUTS) begin
               rdata_next = DATA_W'(general_io_pin_in);
            end
         end
         default: rdata_next = '0;
      endcase
   end

   // read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? rdata_next : '0;
      end
   end

endmodule : servo_and_signal_pulse_unit
`default_nettype wire

// *** pulse_unit_pkg.sv ***
// constants, encodings and register map of the servo and signal pulse unit
`default_nettype none
package pulse_unit_pkg;
   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_PINS = 8;       // general purpose pins
   localparam int NUM_SERVO = 8;      // servo channels, 0-3 in, 4-7 out
   localparam int SERVO_IN_LAST = 3;  // last servo input channel
   localparam int NUM_SIG = 5;        // signal channels on pins 0-4
   localparam int SIG_OUT_FIRST = 1;  // pin 0 has no signal output
   localparam int DATA_W = 16;        // register data width
   localparam int ADDR_W = 8;         // register address width
   localparam int POS_W = 11;         // servo position width
   localparam int MEAS_W = 12;        // servo input us counter width
   localparam int FRAME_W = 16;       // servo frame us counter width
   localparam int PRE_W = 5;          // us prescaler width

   // ----------------------------------------------------------------
   // per-pin function selector
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_INPUT = 3'h0,
      MODE_OUTPUT = 3'h1,
      MODE_SERVO_IN = 3'h2,
      MODE_SERVO_OUT = 3'h3,
      MODE_SIG_OUT = 3'h6,
      MODE_SIG_IN = 3'h7
   } pin_mode_t;

   // ----------------------------------------------------------------
   // register map: address = group * 8 + channel
   // ----------------------------------------------------------------
   localparam logic [4:0] GRP_MODE = 5'h00;       // pin function
   localparam logic [4:0] GRP_SERVO_EN = 5'h01;   // servo enable bit 0
   localparam logic [4:0] GRP_SERVO_POS = 5'h02;  // servo position
   localparam logic [4:0] GRP_SIG_EN = 5'h03;     // signal enable bit 0
   localparam logic [4:0] GRP_SIG_PERIOD = 5'h04; // period in cycles
   localparam logic [4:0] GRP_SIG_HIGH = 5'h05;   // high time in cycles
   localparam logic [4:0] GRP_SIG_COUNT = 5'h06;  // event count, w clears
   localparam logic [4:0] GRP_PIN = 5'h07;        // ch0 level, ch1 inputs
   localparam logic [2:0] PIN_CH_LEVEL = 3'h0;    // plain output levels
   localparam logic [2:0] PIN_CH_INPUTS = 3'h1;   // pin input levels

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam pin_mode_t MODE_RST = MODE_INPUT;
   localparam logic [POS_W-1:0] POS_RST = 11'h000;
   localparam logic [DATA_W-1:0] SIG_PERIOD_RST = 16'h0000;
   localparam logic [DATA_W-1:0] SIG_HIGH_RST = 16'h0000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;      // ref_clk period
   localparam int US_NS = 1000;            // one microsecond in ns
   localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
   localparam int SERVO_FRAME_MS = 20;     // servo frame period
   localparam int SERVO_MIN_MS = 1;        // shortest high phase
   localparam int SERVO_MAX_MS = 2;        // longest high phase
   localparam int SERVO_FRAME_US = SERVO_FRAME_MS * 1000;
   localparam int SERVO_MIN_US = SERVO_MIN_MS * 1000;
   localparam int SERVO_MAX_US = SERVO_MAX_MS * 1000;
   localparam int POS_SPAN = SERVO_MAX_US - SERVO_MIN_US;
endpackage : pulse_unit_pkg
`default_nettype wire

// *** pulse_unit_props.sv ***
// checker watching the ports of the servo and signal pulse unit
`timescale 1ns/1ns
`default_nettype none
module pulse_unit_props
   import pulse_unit_pkg::*;
#(
   parameter int FRAME_US = SERVO_FRAME_US, // servo frame length in us
   parameter int SW = DATA_W                // signal counter width
) (
   input wire logic ref_clk,                          // clock
   input wire logic sys_rst,                          // async reset, high
   input wire logic [ADDR_W-1:0] reg_addr,            // register address
   input wire logic [DATA_W-1:0] reg_wdata,           // write data
   input wire logic reg_wr,                           // write strobe
   input wire logic reg_rd,                           // read strobe
   input wire logic [DATA_W-1:0] reg_rdata,           // read data
   input wire logic [NUM_PINS-1:0] general_io_pin_in,   // pin levels
   input wire logic [NUM_PINS-1:0] general_io_pin_out,  // pin drive
   input wire logic [NUM_PINS-1:0] general_io_pin_oe_n  // low drives
);
   // ----------------------------------------------------------------
   // shadow of the pin modes, rebuilt from bus writes
   // ----------------------------------------------------------------
   logic [2:0] mode_reg [NUM_PINS]; // last mode written per pin
   logic [2:0] rd_mode_reg;         // mode of the pin addressed last cycle
   logic [NUM_PINS-1:0] idle_pin;   // pins whose mode never drives

   // codes 4 and 5 fold to plain input
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_PINS; i++) mode_reg[i] <= 3'h0;
      end else if (reg_wr && reg_addr[7:3] == GRP_MODE) begin
         mode_reg[reg_addr[2:0]] <= (reg_wdata[2:1] == 2'b10) ?
            3'h0 : reg_wdata[2:0];
      end
   end

   // mode seen by a read, lined up with its answer
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) rd_mode_reg <= 3'h0;
      else rd_mode_reg <= mode_reg[reg_addr[2:0]];
   end

   // input, servo input and signal input never drive the pin
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         idle_pin[i] = mode_reg[i] inside {3'h0, 3'h2, 3'h7};
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_rdata_idle:
   assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside the read slot");
   a_reset_pins:
   assert property ($past(sys_rst) |-> general_io_pin_oe_n == 8'hff
      && general_io_pin_out == 8'h00)
      else $error("pins not released after reset");
   a_undriven_low:
   assert property ((general_io_pin_out & general_io_pin_oe_n) == 8'h00)
      else $error("released pin shows a high drive level");
   a_inputs_released:
   assert property ((idle_pin & $past(idle_pin) & ~general_io_pin_oe_n)
      == 8'h00)
      else $error("pin in an input mode is driven");
   a_mode_readback:
   assert property (reg_rd && reg_addr[7:3] == GRP_MODE |=>
      reg_rdata == {13'h0000, rd_mode_reg})
      else $error("mode read back differs from the code written");
   a_unmapped_read:
   assert property (reg_rd && reg_addr[7:6] != 2'b00 |=>
      reg_rdata == 16'h0000)
      else $error("unmapped address read not zero");
   a_sig_ch_range:
   assert property (reg_rd && reg_addr[7:3] inside {[5'h03:5'h06]}
      && reg_addr[2:0] > 3'h4 |=> reg_rdata == 16'h0000)
      else $error("signal channel above four answered");
   a_oe_from_write:
   assert property ($changed(general_io_pin_oe_n) |-> $past(reg_wr)
      || $past(reg_wr, 2) || $past(reg_wr, 3))
      else $error("pin enable changed without a register write");
endmodule : pulse_unit_props

bind servo_and_signal_pulse_unit pulse_unit_props #(
   .FRAME_US(FRAME_US),
   .SW(SW)
) props_u (
   .ref_clk(ref_clk),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .general_io_pin_in(general_io_pin_in),
   .general_io_pin_out(general_io_pin_out),
   .general_io_pin_oe_n(general_io_pin_oe_n)
);
`default_nettype wire

// *** pulse_equipment.sv ***
// model of servo and pulse equipment wired to the general pins
`timescale 1ns/1ns
`default_nettype none
module pulse_equipment
   import pulse_unit_pkg::*;
(
   input wire logic ref_clk,                  // timing reference
   input wire logic [NUM_PINS-1:0] pin_out,   // unit drive level
   input wire logic [NUM_PINS-1:0] pin_oe_n,  // unit enable, low drives
   output logic [NUM_PINS-1:0] pin_level      // resolved pin levels
);
   logic [NUM_PINS-1:0] drive_reg = '0; // pins this equipment pulls high

   // a pin the unit releases shows the equipment, else the unit drive level
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_level[i] = pin_oe_n[i] ? drive_reg[i] : pin_out[i];
      end
   end

   // one high pulse of len cycles on the masked pins
   task automatic pulse(input logic [NUM_PINS-1:0] mask, input int len);
      @(posedge ref_clk);
      drive_reg <= mask;
      repeat (len) @(posedge ref_clk);
      drive_reg <= '0;
   endtask : pulse
endmodule : pulse_equipment
`default_nettype wire

// *** tb.sv ***
// self-checking testbench of the servo and signal pulse unit
`timescale 1ns/1ns
`default_nettype none
module tb
   import pulse_unit_pkg::*;
;
   localparam int FR = 2100; // shortened servo frame in us
   typedef struct {int pin; int per; int hi; int lo_n; int hi_n;} sig_row_t;
   // square wave cases: pin, period, high, low span, high span
   sig_row_t rows [4] = '{'{1, 4, 1, 3, 1}, '{2, 5, 2, 3, 2},
      '{3, 10, 9, 1, 9}, '{4, 2, 1, 1, 1}};
   logic ref_clk;                        // 20 MHz clock
   logic sys_rst;                        // reset, active high
   logic [ADDR_W-1:0] reg_addr;          // bus address
   logic [DATA_W-1:0] reg_wdata;         // bus write data
   logic reg_wr;                         // write strobe
   logic reg_rd;                         // read strobe
   logic [DATA_W-1:0] reg_rdata;         // read data
   logic [NUM_PINS-1:0] pin_in;          // resolved pin levels
   logic [NUM_PINS-1:0] pin_out;         // unit drive
   logic [NUM_PINS-1:0] pin_oe_n;        // unit enable, low drives
   int errors = 0;                       // mismatches
   int comparisons = 0;                  // checks made
   int j4, j5, lo4, hi4, lo5, lo, hi, n; // measured spans

   servo_and_signal_pulse_unit #(.FRAME_US(FR), .SW(16)) dut_u (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .general_io_pin_in(pin_in),
      .general_io_pin_out(pin_out), .general_io_pin_oe_n(pin_oe_n));
   pulse_equipment far_u (.ref_clk(ref_clk), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_level(pin_in));

   // clock source
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   function automatic logic [7:0] ad(input logic [4:0] g, input int c);
      return {g, 3'(c)};
   endfunction : ad

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      check(32'(reg_rdata), 32'(e));
   endtask : rd

   // wait for level lv on pin p, then count the cycles it lasts
   task automatic span(input int p, input logic lv, output int c);
      int w;
      w = 0;
      c = 0;
      while (pin_out[p] !== lv && w < 60000) begin
         @(negedge ref_clk);
         w++;
      end
      while (pin_out[p] === lv && c < 60000) begin
         @(negedge ref_clk);
         c++;
      end
   endtask : span

   task automatic wrap_up();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   // watchdog against a hang
   initial begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      wrap_up();
   end

   // main sequence
   initial begin
      sys_rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(negedge ref_clk);
      check(32'(pin_oe_n), 32'h00ff);
      rd(ad(GRP_SIG_PERIOD, 1), 16'h0000);
      rd(8'h48, 16'h0000);
      rd(ad(GRP_SIG_HIGH, 5), 16'h0000);
      for (int c = 0; c < 8; c++) begin
         wr(ad(GRP_MODE, 6), 16'(c));
         rd(ad(GRP_MODE, 6), (c == 4 || c == 5) ? 16'h0 : 16'(c));
      end
      wr(ad(GRP_MODE, 6), 16'h0000);
      // servo inputs on pins 0-1, outputs on 4, 5 and 7
      wr(ad(GRP_MODE, 0), 16'(MODE_SERVO_IN));
      wr(ad(GRP_MODE, 1), 16'(MODE_SERVO_IN));
      wr(ad(GRP_MODE, 4), 16'(MODE_SERVO_OUT));
      wr(ad(GRP_MODE, 5), 16'(MODE_SERVO_OUT));
      wr(ad(GRP_MODE, 7), 16'(MODE_SERVO_OUT));
      for (int c = 4; c < 7; c++) wr(ad(GRP_SERVO_EN, c), 16'h0001);
      wr(ad(GRP_SERVO_EN, 0), 16'h0001);
      wr(ad(GRP_SERVO_POS, 4), 16'h0000);
      wr(ad(GRP_SERVO_POS, 5), 16'h07d0);
      fork
         begin
            span(4, 1'b1, j4);
            span(4, 1'b0, lo4);
            span(4, 1'b1, hi4);
         end
         begin
            span(5, 1'b1, j5);
            span(5, 1'b0, lo5);
         end
         begin
            far_u.pulse(8'h03, 24000);
            repeat (3) @(posedge ref_clk);
            rd(ad(GRP_SERVO_POS, 0), 16'h00c8);
            rd(ad(GRP_SERVO_POS, 1), 16'h0000);
            far_u.pulse(8'h01, 10000);
            repeat (3) @(posedge ref_clk);
            rd(ad(GRP_SERVO_POS, 0), 16'h0000);
         end
      join
      check(32'(lo4), 32'((FR - SERVO_MIN_US) * CYC_PER_US));
      check(32'(lo4 + hi4), 32'(FR * CYC_PER_US));
      check(32'(lo5), 32'((FR - SERVO_MAX_US) * CYC_PER_US));
      check(32'({pin_oe_n[7:6], pin_out[7]}), 32'h2);
      foreach (rows[i]) begin
         wr(ad(GRP_MODE, rows[i].pin), 16'(MODE_SIG_OUT));
         wr(ad(GRP_SIG_PERIOD, rows[i].pin), 16'(rows[i].per));
         wr(ad(GRP_SIG_HIGH, rows[i].pin), 16'(rows[i].hi));
         wr(ad(GRP_SIG_EN, rows[i].pin), 16'h0001);
         span(rows[i].pin, 1'b1, n);
         span(rows[i].pin, 1'b0, lo);
         span(rows[i].pin, 1'b1, hi);
         check(32'(lo), 32'(rows[i].lo_n));
         check(32'(hi), 32'(rows[i].hi_n));
         wr(ad(GRP_SIG_EN, rows[i].pin), 16'h0000);
      end
      // high time equal to the period holds the pin high
      wr(ad(GRP_SIG_PERIOD, 2), 16'h0003);
      wr(ad(GRP_SIG_HIGH, 2), 16'h0003);
      wr(ad(GRP_SIG_EN, 2), 16'h0001);
      repeat (4) @(negedge ref_clk);
      n = 0;
      repeat (12) begin
         @(negedge ref_clk);
         n += int'(pin_out[2] === 1'b1);
      end
      check(32'(n), 32'd12);
      // event counting on pin 3
      wr(ad(GRP_MODE, 3), 16'(MODE_SIG_IN));
      wr(ad(GRP_SIG_EN, 3), 16'h0001);
      wr(ad(GRP_SIG_COUNT, 3), 16'h0000);
      repeat (3) far_u.pulse(8'h08, 2);
      rd(ad(GRP_SIG_COUNT, 3), 16'h0003);
      wr(ad(GRP_SIG_COUNT, 3), 16'h0000);
      rd(ad(GRP_SIG_COUNT, 3), 16'h0000);
      wr(ad(GRP_SIG_EN, 3), 16'h0000);
      far_u.pulse(8'h08, 2);
      rd(ad(GRP_SIG_COUNT, 3), 16'h0000);
      // plain output mode follows the level register
      wr(ad(GRP_MODE, 6), 16'(MODE_OUTPUT));
      wr(ad(GRP_PIN, 0), 16'h0040);
      rd(ad(GRP_PIN, 0), 16'h0040);
      check(32'(pin_out[6]), 32'h1);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
